// File: design/dad_bank.sv
// Purpose: Small word store standing for each debug region
// Assumes: Requests come from the decoder only
// Notes: Writes blocked when not permitted
`timescale 1ns/100ps
`default_nettype none
module dad_bank #(
  parameter int DEPTH = 4
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic wr_block,
  dad_tgt_if.bank tb
);
  localparam int AW = $clog2(DEPTH);
  // Storage, one row of DEPTH words per target
  logic [dad_pkg::DATA_W-1:0] mem_q [dad_pkg::NUM_TGT][DEPTH];
  logic [dad_pkg::DATA_W-1:0] rd_q, rd_d;
  logic ref_q, ref_d;
  logic [AW-1:0] idx;
  // ************************************************************
  // Answer logic
  // ************************************************************
  assign idx = tb.offs[AW-1:0];
  // Next answer
  always_comb begin
    rd_d = rd_q;
    ref_d = 1'b0;
    if (tb.req) begin
      rd_d = tb.wr ? dad_pkg::ZERO_WORD : mem_q[tb.tgt][idx];
      ref_d = tb.wr & wr_block;
    end
  end
  // Register answer and store writes
  always_ff @(posedge mclk) begin
    if (srst) begin
      rd_q <= dad_pkg::ZERO_WORD;
      ref_q <= 1'b0;
      for (int t = 0; t < dad_pkg::NUM_TGT; t++) begin
        for (int w = 0; w < DEPTH; w++) begin
          mem_q[t][w] <= dad_pkg::ZERO_WORD;
        end
      end
    end else begin
      rd_q <= rd_d;
      ref_q <= ref_d;
      if (tb.req && tb.wr && !wr_block) begin
        mem_q[tb.tgt][idx] <= tb.wdata;
      end
    end
  end
  assign tb.rdata = rd_q;
  assign tb.refuse = ref_q;
endmodule : dad_bank
`default_nettype wire

// File: design/dad_decoder.sv
// Purpose: Debug port slave that decodes regions and answers transfers
// Assumes: Requester follows the two phase port protocol
// Notes: Every access takes one wait cycle, answer in the third cycle
`timescale 1ns/100ps
`default_nettype none
module dad_decoder #(
  parameter bit HAS_CORE1 = 1'b1,
  parameter bit HAS_TRC1 = 1'b1,
  parameter int BANK_DEPTH = 4
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic dbg_port_select,
  input wire logic dbg_access_phase,
  input wire logic dbg_write_not_read,
  input wire logic [dad_pkg::ADDR_HI:dad_pkg::ADDR_LO] dbg_word_addr,
  input wire logic dbg_external_flag,
  input wire logic [dad_pkg::DATA_W-1:0] dbg_write_bus,
  input wire logic sw_debug_permit,
  output logic [dad_pkg::DATA_W-1:0] dbg_read_bus,
  output logic dbg_slave_ready,
  output logic dbg_slave_error
);
  dad_tgt_if tif ();
  // ************************************************************
  // Region decode
  // ************************************************************
  // Map region code to target, valid low when reserved
  function automatic logic [4:0] decode(input logic [4:0] rg);
    logic [4:0] r;
    r = 5'h00;
    case (rg)
      dad_pkg::RG_ROM: r = {1'b1, 4'(dad_pkg::T_ROM)};
      dad_pkg::RG_DBG0: r = {1'b1, 4'(dad_pkg::T_DBG0)};
      dad_pkg::RG_PMU0: r = {1'b1, 4'(dad_pkg::T_PMU0)};
      dad_pkg::RG_DBG1: r = {HAS_CORE1, 4'(dad_pkg::T_DBG1)};
      dad_pkg::RG_PMU1: r = {HAS_CORE1, 4'(dad_pkg::T_PMU1)};
      dad_pkg::RG_XTR0: r = {1'b1, 4'(dad_pkg::T_XTR0)};
      dad_pkg::RG_XTR1: r = {HAS_CORE1, 4'(dad_pkg::T_XTR1)};
      dad_pkg::RG_TRC0: r = {1'b1, 4'(dad_pkg::T_TRC0)};
      dad_pkg::RG_TRC1: r = {HAS_TRC1, 4'(dad_pkg::T_TRC1)};
      default: r = 5'h00;  // Reserved
    endcase
    return r;
  endfunction : decode

  logic [4:0] dec;
  logic [dad_pkg::REGION_W-1:0] region;
  assign region = dbg_word_addr[dad_pkg::ADDR_HI:dad_pkg::REG_LO];
  assign dec = decode(region);

  // ************************************************************
  // Transfer sequencer
  // ************************************************************
  dad_pkg::dad_state_type st_q, st_d;
  logic bad_q, bad_d;                      // Reserved region hit
  logic [dad_pkg::DATA_W-1:0] rd_q, rd_d;  // Read bus register
  logic rdy_q, rdy_d;                      // Ready register
  logic err_q, err_d;                      // Error register
  logic start;                             // Setup phase seen
  logic wr_block;                          // Debug write refused

  assign start = dbg_port_select & ~dbg_access_phase;
  assign wr_block = ~sw_debug_permit & ~dbg_external_flag;

  // Next state and outputs
  always_comb begin
    st_d = st_q;
    bad_d = bad_q;
    rd_d = rd_q;
    rdy_d = 1'b0;
    err_d = 1'b0;
    tif.req = 1'b0;
    case (st_q)
      dad_pkg::DAD_IDLE: begin
        if (start) begin
          st_d = dad_pkg::DAD_WAIT;
          bad_d = ~dec[4];
          tif.req = dec[4];
        end
      end
      dad_pkg::DAD_WAIT: begin
        st_d = dad_pkg::DAD_DONE;
        rdy_d = 1'b1;
        err_d = bad_q | tif.refuse;
        rd_d = (bad_q | dbg_write_not_read) ? dad_pkg::ZERO_WORD : tif.rdata;
      end
      dad_pkg::DAD_DONE: begin
        st_d = dad_pkg::DAD_IDLE;
        rd_d = dad_pkg::ZERO_WORD;
      end
      default: st_d = dad_pkg::DAD_IDLE;
    endcase
  end

  // Register sequencer state
  always_ff @(posedge mclk) begin
    if (srst) begin
      st_q <= dad_pkg::DAD_IDLE;
      bad_q <= 1'b0;
      rd_q <= dad_pkg::ZERO_WORD;
      rdy_q <= 1'b0;
      err_q <= 1'b0;
    end else begin
      st_q <= st_d;
      bad_q <= bad_d;
      rd_q <= rd_d;
      rdy_q <= rdy_d;
      err_q <= err_d;
    end
  end

  // ************************************************************
  // Target request and port outputs
  // ************************************************************
  assign tif.wr = dbg_write_not_read;
  assign tif.tgt = dec[3:0];
  assign tif.offs = dbg_word_addr[dad_pkg::REG_LO-1:dad_pkg::ADDR_LO];
  assign tif.wdata = dbg_write_bus;
  assign dbg_read_bus = rd_q;
  assign dbg_slave_ready = rdy_q;
  assign dbg_slave_error = err_q;

  // ************************************************************
  // Target bank
  // ************************************************************
  dad_bank #(.DEPTH(BANK_DEPTH)) u_bank (
    .mclk(mclk),
    .srst(srst),
    .wr_block(wr_block),
    .tb(tif.bank)
  );

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  logic take;                              // Setup phase taken at this edge
  assign take = start & (st_q == dad_pkg::DAD_IDLE);

  // ************************************************************
  // Handshake timing checks
  // ************************************************************
  // Ready comes exactly two edges after the setup edge
  chk_ready_timing: assert property (
    take |-> !dbg_slave_ready ##1 !dbg_slave_ready ##1 dbg_slave_ready)
    else $error("ready not on third cycle");
  // Ready is a single cycle pulse
  chk_ready_pulse: assert property (
    dbg_slave_ready |=> !dbg_slave_ready)
    else $error("ready held too long");
  // No answer while the port is not selected
  chk_no_select: assert property (
    !dbg_port_select && st_q == dad_pkg::DAD_IDLE |=> !dbg_slave_ready)
    else $error("answer without select");
  // Error only stands together with ready
  chk_err_only_ready: assert property (
    dbg_slave_error |-> dbg_slave_ready)
    else $error("error without ready");

  // ************************************************************
  // Region decode checks
  // ************************************************************
  // Reading the ROM table always completes cleanly
  chk_rom_ok: assert property (
    take && region == dad_pkg::RG_ROM && !dbg_write_not_read |-> ##2 !dbg_slave_error)
    else $error("rom read flagged error");
  // Reserved regions answer with an error
  chk_reserved_err: assert property (
    take && !dec[4] |-> ##2 dbg_slave_error)
    else $error("reserved region not flagged");
  // Core 1 debug region follows the second core option
  chk_core1_map: assert property (
    take && region == dad_pkg::RG_DBG1 && !dbg_write_not_read
      |-> ##2 dbg_slave_error == !HAS_CORE1)
    else $error("core 1 debug decode wrong");
  // Cross trigger 1 follows the second core option
  chk_xtr1_map: assert property (
    take && region == dad_pkg::RG_XTR1 && !dbg_write_not_read
      |-> ##2 dbg_slave_error == !HAS_CORE1)
    else $error("cross trigger 1 decode wrong");
  // Trace cell 1 follows its presence option
  chk_trc1_map: assert property (
    take && region == dad_pkg::RG_TRC1 && !dbg_write_not_read
      |-> ##2 dbg_slave_error == !HAS_TRC1)
    else $error("trace cell 1 decode wrong");
  // Any read of a present region completes without error
  chk_read_ok: assert property (
    take && dec[4] && !dbg_write_not_read |-> ##2 !dbg_slave_error)
    else $error("clean read flagged error");

  // ************************************************************
  // Access source and data checks
  // ************************************************************
  // Write from a non-external source without permit is refused
  chk_write_refused: assert property (
    take && dec[4] && dbg_write_not_read && !sw_debug_permit && !dbg_external_flag
      |-> ##2 dbg_slave_error)
    else $error("blocked write accepted");
  // External debugger accesses are never refused
  chk_ext_write_ok: assert property (
    take && dec[4] && dbg_external_flag |-> ##2 !dbg_slave_error)
    else $error("external access refused");
  // With the permit set every source may write
  chk_permit_write: assert property (
    take && dec[4] && dbg_write_not_read && sw_debug_permit |-> ##2 !dbg_slave_error)
    else $error("permitted write refused");
  // A write answers with an all-zero read bus
  chk_write_rdata: assert property (
    dbg_slave_ready && $past(dbg_write_not_read) |-> dbg_read_bus == dad_pkg::ZERO_WORD)
    else $error("write returned data");
  // Read bus is zero outside the ready cycle
  chk_idle_rdata: assert property (
    !dbg_slave_ready |-> dbg_read_bus == dad_pkg::ZERO_WORD)
    else $error("read data outside ready");

  // Main scenarios
  cov_read_ok: cover property (dbg_slave_ready && !dbg_slave_error);
  cov_error: cover property (dbg_slave_ready && dbg_slave_error);
  cov_refused: cover property (start && dbg_write_not_read && wr_block && dec[4]);
  cov_ext_write: cover property (take && dbg_write_not_read && dbg_external_flag && dec[4]);
  cov_reserved: cover property (take && !dec[4]);
endmodule : dad_decoder
`default_nettype wire

// File: design/dad_pkg.sv
// Purpose: Shared constants for the debug port address decoder
// Assumes: Word addressed debug port, address bits 16 to 2
// Notes: Region codes are address bits 16 to 12
package dad_pkg;
  // ************************************************************
  // Widths
  // ************************************************************
  localparam int ADDR_HI = 16;           // Top word address bit
  localparam int ADDR_LO = 2;            // Lowest word address bit
  localparam int REG_LO = 12;            // Lowest region bit
  localparam int DATA_W = 32;            // Data width
  localparam int REGION_W = 5;           // Region code width
  localparam int OFFS_W = 10;            // Word offset inside region
  localparam int NUM_TGT = 9;            // Region targets
  // ************************************************************
  // Region codes
  // ************************************************************
  localparam logic [4:0] RG_ROM = 5'h00;     // ROM table
  localparam logic [4:0] RG_DBG0 = 5'h10;    // Core 0 debug
  localparam logic [4:0] RG_PMU0 = 5'h11;    // Core 0 perf monitor
  localparam logic [4:0] RG_DBG1 = 5'h12;    // Core 1 debug
  localparam logic [4:0] RG_PMU1 = 5'h13;    // Core 1 perf monitor
  localparam logic [4:0] RG_XTR0 = 5'h18;    // Cross trigger 0
  localparam logic [4:0] RG_XTR1 = 5'h19;    // Cross trigger 1
  localparam logic [4:0] RG_TRC0 = 5'h1C;    // Trace cell 0
  localparam logic [4:0] RG_TRC1 = 5'h1D;    // Trace cell 1
  // ************************************************************
  // Target indices
  // ************************************************************
  localparam int T_ROM = 0;
  localparam int T_DBG0 = 1;
  localparam int T_PMU0 = 2;
  localparam int T_DBG1 = 3;
  localparam int T_PMU1 = 4;
  localparam int T_XTR0 = 5;
  localparam int T_XTR1 = 6;
  localparam int T_TRC0 = 7;
  localparam int T_TRC1 = 8;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000; // Idle read data
  // Transfer states, one bit flips per step except DONE back to IDLE
  typedef enum logic [1:0] {
    DAD_IDLE = 2'b00,
    DAD_WAIT = 2'b01,
    DAD_DONE = 2'b11
  } dad_state_type;
endpackage : dad_pkg

// File: design/dad_tgt_if.sv
// Purpose: Carrier from the decoder to the target register bank
// Assumes: One clock, one target access at a time
// Notes: Request is a one cycle strobe, answer comes next cycle
`timescale 1ns/100ps
`default_nettype none
interface dad_tgt_if;
  logic req;                               // Access strobe
  logic wr;                                // Write when high
  logic [3:0] tgt;                         // Target index
  logic [dad_pkg::OFFS_W-1:0] offs;        // Word offset
  logic [dad_pkg::DATA_W-1:0] wdata;       // Write data
  logic [dad_pkg::DATA_W-1:0] rdata;       // Read data
  logic refuse;                            // Write refused
  modport dec (output req, wr, tgt, offs, wdata, input rdata, refuse);
  modport bank (input req, wr, tgt, offs, wdata, output rdata, refuse);
endinterface : dad_tgt_if
`default_nettype wire

// File: test/dad_req_model.sv
// Purpose: Requester model for the debug port
// Assumes: Tasks are entered at a rising edge
// Notes: Released lines show inverted last values
`timescale 1ns/100ps
`default_nettype none
module dad_req_model (
  input wire logic mclk,
  input wire logic [1:0] rdy,
  input wire logic [1:0] err,
  input wire logic [31:0] rd0,
  input wire logic [31:0] rd1,
  output logic sel,
  output logic en,
  output logic wr,
  output logic [16:2] addr,
  output logic ext,
  output logic [31:0] wd
);
  // ************************************************************
  // Bus tasks
  // ************************************************************
  initial begin
    sel = 1'b0;
    en = 1'b0;
    wr = 1'b0;
    addr = '0;
    ext = 1'b0;
    wd = '0;
  end
  // One transfer; returns at the edge that samples ready high
  // Values read at an edge are those that stood just before it
  task automatic xfer(input logic w, input logic [16:2] a, input logic x,
    input logic [31:0] d, output logic [31:0] q[2], output logic [1:0] e,
    output int lat, output int leak);
    lat = 0;
    leak = 0;
    sel <= 1'b1;
    en <= 1'b0;
    wr <= w;
    addr <= a;
    ext <= x;
    wd <= d;
    @(posedge mclk);
    // Setup edge: the previous answer must be gone
    if (rdy !== 2'b00 || (rd0 | rd1) !== 32'h0000_0000) leak++;
    en <= 1'b1;
    do begin
      @(posedge mclk);
      lat++;
      // Both builds must agree on ready, read bus zero while waiting
      if (rdy !== 2'b11 && (rdy !== 2'b00 || (rd0 | rd1) !== 32'h0000_0000)) leak++;
    end while (rdy !== 2'b11 && lat < 8);
    q[0] = rd0;
    q[1] = rd1;
    e = err;
  endtask : xfer
  // Drop select and scramble the released lines
  task automatic rel;
    sel <= 1'b0;
    en <= 1'b0;
    addr <= ~addr;
    wd <= ~wd;
    @(posedge mclk);
  endtask : rel
  // Bus noise with select low; counts ready seen
  task automatic noise(input int n, output int hits);
    hits = 0;
    repeat (n) begin
      sel <= 1'b0;
      en <= 1'($urandom);
      wr <= 1'b1;
      addr <= 15'($urandom);
      wd <= $urandom;
      @(posedge mclk);
      if (rdy !== 2'b00 || err !== 2'b00) hits++;
    end
  endtask : noise
endmodule : dad_req_model
`default_nettype wire

// File: test/tb_top.sv
// Purpose: Self-checking bench for the debug port decoder
// Assumes: Full and reduced configurations share one requester
// Notes: Behavioural store keyed by instance, region and word
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic mclk, srst, permit, sel, en, wr, ext, rdy0, rdy1;
  wire logic [1:0] err;
  logic [1:0] e;
  logic [16:2] addr;
  logic [31:0] wd, rd0, rd1, d, ex;
  logic [31:0] q[2];
  logic [16:2] a;
  int n_mismatch, total_checks, lat, lk, h, k;
  bit ok;
  logic [31:0] mem [int];
  dad_decoder dut (.mclk(mclk), .srst(srst), .dbg_port_select(sel), .dbg_access_phase(en),
    .dbg_write_not_read(wr), .dbg_word_addr(addr), .dbg_external_flag(ext),
    .dbg_write_bus(wd), .sw_debug_permit(permit), .dbg_read_bus(rd0),
    .dbg_slave_ready(rdy0), .dbg_slave_error(err[0]));
  dad_decoder #(.HAS_CORE1(1'b0), .HAS_TRC1(1'b0)) dut_lite (.mclk(mclk), .srst(srst),
    .dbg_port_select(sel), .dbg_access_phase(en), .dbg_write_not_read(wr),
    .dbg_word_addr(addr), .dbg_external_flag(ext), .dbg_write_bus(wd),
    .sw_debug_permit(permit), .dbg_read_bus(rd1), .dbg_slave_ready(rdy1),
    .dbg_slave_error(err[1]));
  dad_req_model req (.mclk(mclk), .rdy({rdy1, rdy0}), .err(err), .rd0(rd0), .rd1(rd1),
    .sel(sel), .en(en), .wr(wr), .addr(addr), .ext(ext), .wd(wd));
  // ************************************************************
  // Reference and checks
  // ************************************************************
  // Region present in the full (0) or reduced (1) build
  function automatic bit present(input int lite, input logic [4:0] r);
    case (r)
      5'h00, 5'h10, 5'h11, 5'h18, 5'h1C: present = 1'b1;
      5'h12, 5'h13, 5'h19, 5'h1D: present = (lite == 0);
      default: present = 1'b0;
    endcase
  endfunction : present
  task automatic cmp_data(input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask : cmp_data
  task automatic cmp_flag(input logic exp, input logic got);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask : cmp_flag
  task automatic wrap_up;
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : wrap_up
  // ************************************************************
  // Stimulus
  // ************************************************************
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  initial begin
    #(20000 * 5);
    n_mismatch++;
    wrap_up();
  end
  initial begin
    srst = 1'b1;
    permit = 1'b0;
    void'($urandom(32'hC5E5));
    repeat (3) @(posedge mclk);
    srst <= 1'b0;
    for (int r = 0; r < 32; r++) begin
      req.noise(2, h);
      cmp_data(32'h0, 32'(h));
      for (int c = 0; c < 4; c++) begin
        a = {r[4:0], 8'h00, 2'($urandom_range(3))};
        d = $urandom;
        permit <= c[1];
        req.xfer(1'b1, a, c[0], d, q, e, lat, lk);
        cmp_data(32'h0000_0002, 32'(lat));
        cmp_data(32'h0000_0000, 32'(lk));
        for (int i = 0; i < 2; i++) begin
          ok = present(i, r[4:0]) && (c[1] || c[0]);
          if (ok) mem[i * 128 + r * 4 + a[3:2]] = d;
          cmp_data(32'h0000_0000, q[i]);
          cmp_flag(!ok, e[i]);
        end
        req.xfer(1'b0, a, 1'($urandom), ~d, q, e, lat, lk);
        cmp_data(32'h0000_0002, 32'(lat));
        cmp_data(32'h0000_0000, 32'(lk));
        for (int i = 0; i < 2; i++) begin
          k = i * 128 + r * 4 + a[3:2];
          ok = present(i, r[4:0]);
          ex = (ok && mem.exists(k)) ? mem[k] : 32'h0000_0000;
          cmp_data(ex, q[i]);
          cmp_flag(!ok, e[i]);
        end
        req.rel();
      end
    end
    wrap_up();
  end
endmodule : tb_top
`default_nettype wire
